// [scdsp_chk.sv]
// Concurrent checks on the command dispatcher ports
`timescale 1ns/1ps
module scdsp_chk
  import scdsp_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic       cmd_we_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic       seq_done_i,
  input wire logic       scsi_rst_n_i,
  input wire logic       initiator_i,
  input wire logic       target_i,
  input wire logic       command_busy_flag_o,
  input wire logic [7:0] interrupt_source_reg_o,
  input wire logic       irq_o,
  input wire logic [7:0] operating_mode_reg_o,
  input wire logic       controller_function_enable_o,
  input wire logic [7:0] aux_pulse_o,
  input wire logic       seq_start_o,
  input wire logic [1:0] seq_count_sel_o,
  input wire logic       chip_reset_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_cmd(logic [7:0] c);
    cmd_we_i && cmd_data_i == c && !chip_reset_o;
  endsequence
  // Transfer code with any count bits
  sequence s_xfer;
    cmd_we_i && cmd_data_i[5:0] == 6'h12 && !chip_reset_o && !command_busy_flag_o;
  endsequence

  a_reset_defaults: assert property ($rose(rst_n_i) |->
    operating_mode_reg_o == MODE_RST_VAL && !controller_function_enable_o &&
    !command_busy_flag_o && irq_o && interrupt_source_reg_o == IRQ_RESET)
    else $error("reset defaults wrong");
  a_break_idle: assert property (s_cmd(CMD_BREAK) ##0 !command_busy_flag_o
    |=> aux_pulse_o == 8'h00) else $error("break ran while idle");
  a_break_busy: assert property (s_cmd(CMD_BREAK) ##0 command_busy_flag_o
    |=> aux_pulse_o == 8'h01) else $error("break lost while busy");
  a_busrst_fen: assert property (s_cmd(CMD_BUS_RESET)
    |=> aux_pulse_o[3] == $past(controller_function_enable_o)) else $error("bus reset gate");
  a_aux_clear: assert property (s_cmd(CMD_CLEAR_FIFO) |=> aux_pulse_o == 8'h04)
    else $error("clear fifo pulse wrong");
  a_seq_launch: assert property (s_xfer ##0 !initiator_i && !target_i |=>
    command_busy_flag_o ##1 (seq_start_o && seq_count_sel_o == $past(cmd_data_i[7:6], 2)))
    else $error("sequenced launch wrong");
  a_seq_invalid: assert property (s_xfer ##0 (initiator_i || target_i) |=>
    irq_o && interrupt_source_reg_o == IRQ_INVALID && !command_busy_flag_o)
    else $error("invalid command not flagged");
  a_done_irq: assert property (seq_done_i && command_busy_flag_o && !cmd_we_i &&
    !chip_reset_o |=> !command_busy_flag_o && irq_o && interrupt_source_reg_o == IRQ_CMD_DONE)
    else $error("termination interrupt wrong");
  a_chip_rst: assert property (s_cmd(CMD_CHIP_RESET) |=> chip_reset_o [*4] ##1
    (!chip_reset_o && irq_o && interrupt_source_reg_o == IRQ_RESET))
    else $error("chip reset sequence wrong");
  a_bus_rst_irq: assert property ($fell(scsi_rst_n_i) && !chip_reset_o |->
    ##[2:4] interrupt_source_reg_o == IRQ_BUS_RST) else $error("bus reset not reported");
endmodule // scdsp_chk

bind scdsp_dispatch scdsp_chk u_chk (.*);

// [scdsp_decode.sv]
// Combinational command byte decoder
`timescale 1ns/1ps
module scdsp_decode
  import scdsp_pkg::*;
(
  input  wire logic [7:0] cmd_byte_i,
  output scdsp_cmd_t      cmd_class_o,
  output logic            count_select_hi_o,
  output logic            count_select_lo_o,
  output logic            attention_choice_bit_o,
  output logic            info_type_hi_o,
  output logic            info_type_lo_o,
  output logic            sequenced_o
);

  always_comb begin
    cmd_class_o = SCD_C_NONE;
    unique casez (cmd_byte_i)
      CMD_CHIP_RESET: cmd_class_o = SCD_C_CHIP_RST;
      CMD_BREAK:      cmd_class_o = SCD_C_BREAK;
      CMD_DISCONNECT: cmd_class_o = SCD_C_DISC;
      CMD_CLEAR_FIFO: cmd_class_o = SCD_C_CLR_FIFO;
      CMD_BUS_RESET:  cmd_class_o = SCD_C_BUS_RST;
      CMD_SET_ATN:    cmd_class_o = SCD_C_SET_ATN;
      CMD_ACK_REL:    cmd_class_o = SCD_C_ACK_REL;
      8'b0001?000:    cmd_class_o = SCD_C_SELECT;
      8'b??010010:    cmd_class_o = SCD_C_TRANSFER;
      8'b??01?100:    cmd_class_o = SCD_C_AUTO_INI;
      8'b??010101:    cmd_class_o = SCD_C_AUTO_INI2;
      CMD_RESELECT:   cmd_class_o = SCD_C_RESELECT;
      CMD_AUTO_TGT:   cmd_class_o = SCD_C_AUTO_TGT;
      CMD_AUTO_TGT2:  cmd_class_o = SCD_C_AUTO_TGT2;
      8'b??101??0:    cmd_class_o = SCD_C_RECEIVE;
      8'b??101??1:    cmd_class_o = SCD_C_SEND;
      8'b??111000:    cmd_class_o = SCD_C_RE_RECV;
      8'b??111001:    cmd_class_o = SCD_C_RE_SEND;
      default:        cmd_class_o = SCD_C_NONE;
    endcase
  end

  // Fields only carry meaning in commands that hold them
  always_comb begin
    count_select_hi_o      = cmd_byte_i[CNT_SEL_HI_POS];
    count_select_lo_o      = cmd_byte_i[CNT_SEL_LO_POS];
    attention_choice_bit_o = cmd_byte_i[ATTN_POS] &
                             (cmd_class_o == SCD_C_SELECT || cmd_class_o == SCD_C_AUTO_INI);
    info_type_hi_o         = cmd_byte_i[INFO_HI_POS] &
                             (cmd_class_o == SCD_C_RECEIVE || cmd_class_o == SCD_C_SEND);
    info_type_lo_o         = cmd_byte_i[INFO_LO_POS] &
                             (cmd_class_o == SCD_C_RECEIVE || cmd_class_o == SCD_C_SEND);
    sequenced_o            = (cmd_class_o >= SCD_C_SELECT);
  end

endmodule // scdsp_decode

// [scdsp_dispatch.sv]
// Command decode, busy rules, reset defaults and bus event dispatch
`timescale 1ns/1ps
// Function
// - Decode group I command codes
// - Decode group II command codes
// - Decode group III command codes
// - Top bits count select, bit 3 attention
// - Receive/send bits 2..1 choose phase
// - Auxiliary commands run at once, then wait
// - Chip reset resets, then reset interrupt
// - Sequenced commands synchronised, interrupt at end
// - Respond to selection while disconnected
// - Initiator reports bus phase changes
// - Bus reset watched except during chip reset, host notified
// - Auxiliary and chip reset accepted while busy
// - Break ignored unless busy
// - Reset interrupt after pin or chip reset
// - Reset clears registers except kept ones
// - Mode resets with parity disabled
// - Selection responses disabled after reset
// - Bus reset command needs controller enable
// - Sequenced command outside disconnect is invalid
module scdsp_dispatch
  import scdsp_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       cmd_we_i,
  input  wire logic [7:0] cmd_data_i,
  input  wire logic       mode_we_i,
  input  wire logic [7:0] mode_data_i,
  input  wire logic       fen_we_i,
  input  wire logic       fen_data_i,
  input  wire logic       ist_rd_i,
  input  wire logic       seq_done_i,
  input  wire logic       scsi_rst_n_i,
  input  wire logic       scsi_sel_n_i,
  input  wire logic       scsi_io_n_i,
  input  wire logic [2:0] scsi_phase_i,
  input  wire logic       initiator_i,
  input  wire logic       target_i,
  output logic            command_busy_flag_o,
  output logic [7:0]      interrupt_source_reg_o,
  output logic            irq_o,
  output logic [7:0]      operating_mode_reg_o,
  output logic            controller_function_enable_o,
  output logic [7:0]      aux_pulse_o,
  output logic [4:0]      seq_cmd_o,
  output logic            seq_start_o,
  output logic [1:0]      seq_count_sel_o,
  output logic            seq_attention_o,
  output logic [1:0]      seq_info_type_o,
  output logic            response_start_o,
  output logic            chip_reset_o
);

  scdsp_cmd_t   cmd_class;
  logic         cnt_hi;
  logic         cnt_lo;
  logic         attn;
  logic         info_hi;
  logic         info_lo;
  logic         is_seq;
  logic [5:0]   bus_s;
  logic         bus_rst;
  logic         bus_sel;
  logic         bus_io;
  logic [2:0]   bus_phase;

  scdsp_state_t state;
  scdsp_state_t next_state;
  logic         busy;
  logic         next_busy;
  logic [7:0]   interrupt_source_reg;
  logic [7:0]   next_ist;
  logic         irq;
  logic         next_irq;
  logic [7:0]   mode;
  logic [7:0]   next_mode;
  logic         controller_function_enable;
  logic         next_fen;
  logic [7:0]   aux;
  logic [7:0]   next_aux;
  logic [7:0]   held_cmd;
  logic [7:0]   next_held_cmd;
  logic [4:0]   seq_cmd;
  logic [4:0]   next_seq_cmd;
  logic         seq_start;
  logic         next_seq_start;
  logic [1:0]   cnt_sel;
  logic [1:0]   next_cnt_sel;
  logic         seq_attn;
  logic         next_seq_attn;
  logic [1:0]   info;
  logic [1:0]   next_info;
  logic         resp;
  logic         next_resp;
  logic [2:0]   crst_cnt;
  logic [2:0]   next_crst_cnt;
  logic         rst_seen;
  logic         next_rst_seen;
  logic         sel_seen;
  logic         next_sel_seen;
  logic [2:0]   last_phase;
  logic [2:0]   next_last_phase;
  logic         crst;
  logic         next_crst;

  scdsp_decode u_decode (
    .cmd_byte_i             (cmd_data_i),
    .cmd_class_o            (cmd_class),
    .count_select_hi_o      (cnt_hi),
    .count_select_lo_o      (cnt_lo),
    .attention_choice_bit_o (attn),
    .info_type_hi_o         (info_hi),
    .info_type_lo_o         (info_lo),
    .sequenced_o            (is_seq)
  );

  // Bus lines come from pins, so they pass two flops first
  scdsp_sync #(.WIDTH(6)) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    ({~scsi_rst_n_i, ~scsi_sel_n_i, ~scsi_io_n_i, scsi_phase_i}),
    .sync_o     (bus_s)
  );

  assign bus_rst   = bus_s[5];
  assign bus_sel   = bus_s[4];
  assign bus_io    = bus_s[3];
  assign bus_phase = bus_s[2:0];

  // One auxiliary pulse bit per auxiliary command class; every other class gives none
  function automatic logic [7:0] aux_bit(input scdsp_cmd_t c);
    logic [7:0] v;
    v = 8'h00;
    unique case (c)
      SCD_C_BREAK:    v = 8'h01;
      SCD_C_DISC:     v = 8'h02;
      SCD_C_CLR_FIFO: v = 8'h04;
      SCD_C_BUS_RST:  v = 8'h08;
      SCD_C_SET_ATN:  v = 8'h10;
      SCD_C_ACK_REL:  v = 8'h20;
      default:        v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    next_state      = state;
    next_busy       = busy;
    next_ist        = interrupt_source_reg;
    next_irq        = irq;
    next_mode       = mode;
    next_fen        = controller_function_enable;
    next_aux        = 8'h00;
    next_held_cmd   = held_cmd;
    next_seq_cmd    = seq_cmd;
    next_seq_start  = 1'b0;
    next_cnt_sel    = cnt_sel;
    next_seq_attn   = seq_attn;
    next_info       = info;
    next_resp       = 1'b0;
    next_crst_cnt   = crst_cnt;
    next_rst_seen   = bus_rst;
    next_sel_seen   = bus_sel;
    next_last_phase = bus_phase;
    next_crst       = 1'b0;

    // Host read clears the pending interrupt unless a selection left unanswered arrives with it; a same-cycle event below wins
    if (ist_rd_i) begin
      next_irq = 1'b0;
      next_ist = IRQ_NONE;
    end
    if (mode_we_i) begin
      next_mode = mode_data_i;
    end
    if (fen_we_i) begin
      next_fen = fen_data_i;
    end

    unique case (state)
      SCD_S_WAIT, SCD_S_RUN: begin
        if (state == SCD_S_RUN && seq_done_i) begin
          next_state = SCD_S_WAIT;
          next_busy  = 1'b0;
          next_irq   = 1'b1;
          next_ist   = IRQ_CMD_DONE;
        end
        if (state == SCD_S_WAIT && !busy) begin
          if (bus_sel && !sel_seen && !initiator_i && !target_i) begin
            next_resp = 1'b1;
            next_irq  = 1'b1;
            next_ist  = bus_io ? IRQ_RESELECTED : IRQ_SELECTED;
            if (bus_io && !mode[MODE_RESELECT_RESPONSE_ENABLE_POS]) begin
              next_resp = 1'b0;
              next_irq  = irq;
              next_ist  = interrupt_source_reg;
            end
            if (!bus_io && !mode[MODE_SELECT_RESPONSE_ENABLE_POS]) begin
              next_resp = 1'b0;
              next_irq  = irq;
              next_ist  = interrupt_source_reg;
            end
          end
          if (initiator_i && bus_phase != last_phase) begin
            next_irq = 1'b1;
            next_ist = IRQ_PHASE_CHG;
          end
        end
        if (bus_rst && !rst_seen) begin
          next_irq = 1'b1;
          next_ist = IRQ_BUS_RST;
        end
        // Auxiliary commands other than break are taken in every state except chip reset, busy or not
        if (cmd_we_i) begin
          if (cmd_class == SCD_C_CHIP_RST) begin
            next_state    = SCD_S_CRST;
            next_crst_cnt = 3'(CHIP_RST_CYCLES - 1);
            next_crst     = 1'b1;
          end else if (cmd_class == SCD_C_BREAK) begin
            if (busy) begin
              next_aux = aux_bit(cmd_class);
            end
          end else if (cmd_class == SCD_C_BUS_RST) begin
            if (controller_function_enable) begin
              next_aux = aux_bit(cmd_class);
            end
          end else if (!is_seq && cmd_class != SCD_C_NONE) begin
            next_aux = aux_bit(cmd_class);
          end else if (is_seq && !busy) begin
            if (initiator_i || target_i) begin
              next_irq = 1'b1;
              next_ist = IRQ_INVALID;
            end else begin
              // Byte held one cycle so the sequencer sees stable fields
              next_state    = SCD_S_SYNC;
              next_busy     = 1'b1;
              next_held_cmd = cmd_data_i;
              next_seq_cmd  = 5'(cmd_class);
              next_cnt_sel  = {cnt_hi, cnt_lo};
              next_seq_attn = attn;
              next_info     = {info_hi, info_lo};
            end
          end
        end
      end
      SCD_S_SYNC: begin
        next_state     = SCD_S_RUN;
        next_seq_start = 1'b1;
        if (bus_rst && !rst_seen) begin
          next_irq = 1'b1;
          next_ist = IRQ_BUS_RST;
        end
        if (cmd_we_i && cmd_class == SCD_C_CHIP_RST) begin
          next_state    = SCD_S_CRST;
          next_crst_cnt = 3'(CHIP_RST_CYCLES - 1);
          next_crst     = 1'b1;
          next_seq_start = 1'b0;
        end else if (cmd_we_i && !is_seq && cmd_class != SCD_C_NONE) begin
          // Auxiliary commands stay live in the one-cycle sync slot
          if (cmd_class != SCD_C_BUS_RST || controller_function_enable) begin
            next_aux = aux_bit(cmd_class);
          end
        end
      end
      SCD_S_CRST: begin
        next_crst = 1'b1;
        next_busy = 1'b0;
        next_mode = MODE_RST_VAL;
        next_fen  = 1'b0;
        if (crst_cnt == 3'h0) begin
          next_state = SCD_S_WAIT;
          next_crst  = 1'b0;
          next_irq   = 1'b1;
          next_ist   = IRQ_RESET;
        end else begin
          next_crst_cnt = crst_cnt - 3'h1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state      <= SCD_S_WAIT;
      busy       <= 1'b0;
      interrupt_source_reg        <= IRQ_RESET;
      irq        <= 1'b1;
      mode       <= MODE_RST_VAL;
      controller_function_enable        <= 1'b0;
      aux        <= REG_CLEAR_VAL;
      held_cmd   <= REG_CLEAR_VAL;
      seq_cmd    <= 5'h00;
      seq_start  <= 1'b0;
      cnt_sel    <= 2'b00;
      seq_attn   <= 1'b0;
      info       <= 2'b00;
      resp       <= 1'b0;
      crst_cnt   <= 3'h0;
      rst_seen   <= 1'b0;
      sel_seen   <= 1'b0;
      last_phase <= 3'h0;
      crst       <= 1'b0;
    end else begin
      state      <= next_state;
      busy       <= next_busy;
      interrupt_source_reg        <= next_ist;
      irq        <= next_irq;
      mode       <= next_mode;
      controller_function_enable        <= next_fen;
      aux        <= next_aux;
      held_cmd   <= next_held_cmd;
      seq_cmd    <= next_seq_cmd;
      seq_start  <= next_seq_start;
      cnt_sel    <= next_cnt_sel;
      seq_attn   <= next_seq_attn;
      info       <= next_info;
      resp       <= next_resp;
      crst_cnt   <= next_crst_cnt;
      rst_seen   <= next_rst_seen;
      sel_seen   <= next_sel_seen;
      last_phase <= next_last_phase;
      crst       <= next_crst;
    end
  end

  assign command_busy_flag_o          = busy;
  assign interrupt_source_reg_o       = interrupt_source_reg;
  assign irq_o                        = irq;
  assign operating_mode_reg_o         = mode;
  assign controller_function_enable_o = controller_function_enable;
  assign aux_pulse_o                  = aux;
  assign seq_cmd_o                    = seq_cmd;
  assign seq_start_o                  = seq_start;
  assign seq_count_sel_o              = cnt_sel;
  assign seq_attention_o              = seq_attn;
  assign seq_info_type_o              = info;
  assign response_start_o             = resp;
  assign chip_reset_o                 = crst;

endmodule // scdsp_dispatch

// [scdsp_pkg.sv]
// Package of command codes, reset values and states for the command dispatcher
package scdsp_pkg;

  // Group I command codes
  localparam logic [7:0] CMD_CHIP_RESET = 8'h00;
  localparam logic [7:0] CMD_BREAK      = 8'h01;
  localparam logic [7:0] CMD_DISCONNECT = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FIFO = 8'h05;
  localparam logic [7:0] CMD_BUS_RESET  = 8'h08;
  // Group II fixed codes
  localparam logic [7:0] CMD_SET_ATN    = 8'h03;
  localparam logic [7:0] CMD_ACK_REL    = 8'h04;
  // Group III fixed codes
  localparam logic [7:0] CMD_RESELECT   = 8'h20;
  localparam logic [7:0] CMD_AUTO_TGT   = 8'h30;
  localparam logic [7:0] CMD_AUTO_TGT2  = 8'h31;

  // Field positions in the command byte
  localparam int CNT_SEL_HI_POS = 7;
  localparam int CNT_SEL_LO_POS = 6;
  localparam int ATTN_POS       = 3;
  localparam int INFO_HI_POS    = 2;
  localparam int INFO_LO_POS    = 1;

  // Reset values
  localparam logic [7:0] REG_CLEAR_VAL  = 8'h00;
  localparam logic [7:0] MODE_RST_VAL   = 8'h40;
  localparam int MODE_HPS_POS           = 7;
  localparam int MODE_DHP_POS           = 6;
  localparam int MODE_RESELECT_RESPONSE_ENABLE_POS          = 1;
  localparam int MODE_SELECT_RESPONSE_ENABLE_POS          = 0;

  // Cycles the internal reset takes after a chip reset
  localparam int CHIP_RST_CYCLES        = 4;

  // Interrupt source codes
  localparam logic [7:0] IRQ_NONE       = 8'h00;
  localparam logic [7:0] IRQ_RESET      = 8'h01;
  localparam logic [7:0] IRQ_CMD_DONE   = 8'h02;
  localparam logic [7:0] IRQ_INVALID    = 8'h03;
  localparam logic [7:0] IRQ_SELECTED   = 8'h04;
  localparam logic [7:0] IRQ_RESELECTED = 8'h05;
  localparam logic [7:0] IRQ_PHASE_CHG  = 8'h06;
  localparam logic [7:0] IRQ_BUS_RST    = 8'h07;

  // Command classes
  typedef enum logic [4:0] {
    SCD_C_NONE      = 5'h00,
    SCD_C_CHIP_RST  = 5'h01,
    SCD_C_BREAK     = 5'h02,
    SCD_C_DISC      = 5'h03,
    SCD_C_CLR_FIFO  = 5'h04,
    SCD_C_BUS_RST   = 5'h05,
    SCD_C_SET_ATN   = 5'h06,
    SCD_C_ACK_REL   = 5'h07,
    SCD_C_SELECT    = 5'h08,
    SCD_C_TRANSFER  = 5'h09,
    SCD_C_AUTO_INI  = 5'h0A,
    SCD_C_AUTO_INI2 = 5'h0B,
    SCD_C_RESELECT  = 5'h0C,
    SCD_C_RECEIVE   = 5'h0D,
    SCD_C_SEND      = 5'h0E,
    SCD_C_AUTO_TGT  = 5'h0F,
    SCD_C_AUTO_TGT2 = 5'h10,
    SCD_C_RE_RECV   = 5'h11,
    SCD_C_RE_SEND   = 5'h12
  } scdsp_cmd_t;

  // Connection status of the controller
  typedef enum logic [1:0] {
    SCD_ST_DISC = 2'b00,
    SCD_ST_INIT = 2'b01,
    SCD_ST_TGT  = 2'b10
  } scdsp_conn_t;

  // Dispatcher states
  typedef enum logic [1:0] {
    SCD_S_WAIT  = 2'b00,
    SCD_S_SYNC  = 2'b01,
    SCD_S_RUN   = 2'b10,
    SCD_S_CRST  = 2'b11
  } scdsp_state_t;

endpackage

// [scdsp_seq_model.sv]
// Phase sequencer stand-in that ends each sequenced command
`timescale 1ns/1ps
module scdsp_seq_model (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       seq_start_i,
  input  wire logic       break_i,
  input  wire logic       chip_reset_i,
  input  wire logic [3:0] delay_i,
  output logic            seq_done_o
);
  logic [4:0] cnt;
  logic       run;
  always_ff @(posedge core_clk_i) begin
    seq_done_o <= 1'b0;
    // Internal reset kills the running command without a done pulse
    if (!rst_n_i || chip_reset_i) begin
      run <= 1'b0;
      cnt <= 5'h00;
    end else if (seq_start_i) begin
      run <= 1'b1;
      cnt <= {1'b0, delay_i};
    end else if (run && (cnt == 5'h00 || break_i)) begin
      run        <= 1'b0;
      seq_done_o <= 1'b1;
    end else if (run) begin
      cnt <= cnt - 5'h01;
    end
  end
endmodule // scdsp_seq_model

// [scdsp_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module scdsp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
    end
  end

  assign sync_o = stage2;

endmodule // scdsp_sync

// [tb_top.sv]
// Self-checking bench for the command dispatcher
`timescale 1ns/1ps
module tb_top;
  import scdsp_pkg::*;
  logic       core_clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       cmd_we_i = 1'b0, mode_we_i = 1'b0, fen_we_i = 1'b0, ist_rd_i = 1'b0;
  logic [7:0] cmd_data_i = 8'h00, mode_data_i = 8'h00;
  logic       fen_data_i = 1'b0, seq_done;
  logic       sel_n = 1'b1, io_n = 1'b1, rst_pin_n = 1'b1, ini = 1'b0, tgt = 1'b0;
  logic [2:0] phase = 3'h0;
  logic [3:0] dly = 4'h0;
  logic       busy, irq, controller_function_enable, start, att, resp, chip_rst;
  logic [7:0] src, mode, aux, resp_cnt = 8'h00;
  logic [1:0] cnt_sel, info;
  scdsp_cmd_t seq_cmd;
  int         errors = 0, checked = 0, cycles = 0;
  logic [31:0] seed = 32'd98;
  localparam logic [7:0] BASE [11] = '{8'h10, 8'h12, 8'h14, 8'h15, 8'h20, 8'h28, 8'h29,
                                        8'h30, 8'h31, 8'h38, 8'h39};
  localparam logic [7:0] MASK [11] = '{8'h08, 8'hC0, 8'hC8, 8'hC0, 8'h00, 8'hC6, 8'hC6,
                                        8'h00, 8'h00, 8'hC0, 8'hC0};
  localparam scdsp_cmd_t CLS [11] = '{SCD_C_SELECT, SCD_C_TRANSFER, SCD_C_AUTO_INI,
    SCD_C_AUTO_INI2, SCD_C_RESELECT, SCD_C_RECEIVE, SCD_C_SEND, SCD_C_AUTO_TGT,
    SCD_C_AUTO_TGT2, SCD_C_RE_RECV, SCD_C_RE_SEND};
  localparam logic [7:0] AUX_CMD [4] = '{CMD_DISCONNECT, CMD_CLEAR_FIFO, CMD_SET_ATN, CMD_ACK_REL};
  localparam logic [7:0] AUX_BIT [4] = '{8'h02, 8'h04, 8'h10, 8'h20};

  always #20 core_clk_i = ~core_clk_i;

  scdsp_dispatch u_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cmd_we_i(cmd_we_i), .cmd_data_i(cmd_data_i),
    .mode_we_i(mode_we_i), .mode_data_i(mode_data_i), .fen_we_i(fen_we_i),
    .fen_data_i(fen_data_i), .ist_rd_i(ist_rd_i), .seq_done_i(seq_done),
    .scsi_rst_n_i(rst_pin_n), .scsi_sel_n_i(sel_n), .scsi_io_n_i(io_n), .scsi_phase_i(phase),
    .initiator_i(ini), .target_i(tgt), .command_busy_flag_o(busy),
    .interrupt_source_reg_o(src), .irq_o(irq), .operating_mode_reg_o(mode),
    .controller_function_enable_o(controller_function_enable), .aux_pulse_o(aux), .seq_cmd_o(seq_cmd),
    .seq_start_o(start), .seq_count_sel_o(cnt_sel), .seq_attention_o(att),
    .seq_info_type_o(info), .response_start_o(resp), .chip_reset_o(chip_rst));

  scdsp_seq_model u_seq (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .seq_start_i(start), .break_i(aux[0]),
    .chip_reset_i(chip_rst), .delay_i(dly), .seq_done_o(seq_done));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic summarize();
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // Kind 0 command, 1 mode, 2 function enable, 3 interrupt source read
  task automatic strobe(input int k, input logic [7:0] d);
    @(posedge core_clk_i);
    cmd_we_i    <= (k == 0);
    mode_we_i   <= (k == 1);
    fen_we_i    <= (k == 2);
    ist_rd_i    <= (k == 3);
    cmd_data_i  <= d;
    mode_data_i <= d;
    fen_data_i  <= d[0];
    @(posedge core_clk_i);
    {cmd_we_i, mode_we_i, fen_we_i, ist_rd_i} <= 4'h0;
    #1;
  endtask

  task automatic wait_idle();
    for (int n = 0; n < 60 && busy !== 1'b0; n++) tick(1);
  endtask

  task automatic run_seq(input int k, input logic [7:0] r);
    logic [7:0] b;
    b = BASE[k] | (r & MASK[k]);
    dly = r[3:0];
    wait_idle();
    strobe(0, b);
    chk(8'(busy), 8'h01);
    tick(1);
    chk(8'(start), 8'h01);
    chk(8'(seq_cmd), 8'(CLS[k]));
    chk(8'(cnt_sel), 8'(b[7:6]));
    if (k == 0 || k == 2) chk(8'(att), 8'(b[3]));
    if (k == 5 || k == 6) chk(8'(info), 8'(b[2:1]));
  endtask

  task automatic end_seq();
    wait_idle();
    chk(8'(busy), 8'h00);
    chk({irq, src}, {1'b1, IRQ_CMD_DONE});
    strobe(3, 8'h00);
    chk({irq, src}, {1'b0, IRQ_NONE});
  endtask

  // Selection edge held long enough to pass the pin synchroniser
  task automatic bus_ev(input logic io);
    io_n  <= io;
    sel_n <= 1'b0;
    tick(5);
    sel_n <= 1'b1;
    tick(3);
  endtask

  always @(posedge core_clk_i) begin
    if (resp === 1'b1) resp_cnt <= resp_cnt + 8'h01;
    cycles++;
    if (cycles == 6000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    logic [7:0] r;
    int         k;
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk(mode, MODE_RST_VAL);
    chk(8'(controller_function_enable), 8'h00);
    chk({irq, src}, {1'b1, IRQ_RESET});
    strobe(3, 8'h00);
    chk(8'(irq), 8'h00);
    strobe(0, CMD_BREAK);
    chk(aux, 8'h00);
    strobe(0, CMD_BUS_RESET);
    chk(aux, 8'h00);
    strobe(2, 8'h01);
    strobe(0, CMD_BUS_RESET);
    chk(aux, 8'h08);
    for (int i = 0; i < 4; i++) begin
      strobe(0, AUX_CMD[i]);
      chk(aux, AUX_BIT[i]);
    end
    bus_ev(1'b1);
    chk({irq, resp_cnt}, 9'h000);
    strobe(1, 8'h43);
    bus_ev(1'b1);
    chk({resp_cnt, src}, {8'h01, IRQ_SELECTED});
    strobe(3, 8'h00);
    bus_ev(1'b0);
    chk({resp_cnt, src}, {8'h02, IRQ_RESELECTED});
    strobe(3, 8'h00);
    ini <= 1'b1;
    tick(4);
    phase <= ~phase;
    tick(5);
    chk(src, IRQ_PHASE_CHG);
    strobe(3, 8'h00);
    strobe(0, 8'h12);
    chk({busy, src}, {1'b0, IRQ_INVALID});
    strobe(3, 8'h00);
    {ini, tgt} <= 2'b01;
    strobe(0, CMD_AUTO_TGT);
    chk({busy, src}, {1'b0, IRQ_INVALID});
    strobe(3, 8'h00);
    tgt <= 1'b0;
    tick(2);
    for (int i = 0; i < 40; i++) begin
      k = int'(xs() % 11);
      r = 8'(xs());
      if (r[5]) r[3:0] = 4'hF;
      run_seq(k, r);
      if (r[4]) begin
        strobe(0, CMD_CLEAR_FIFO);
        chk(aux, 8'h04);
      end
      if (r[5]) begin
        strobe(0, CMD_BREAK);
        chk(aux, 8'h01);
      end
      end_seq();
    end
    run_seq(1, 8'h0F);
    rst_pin_n <= 1'b0;
    tick(5);
    chk({irq, src}, {1'b1, IRQ_BUS_RST});
    rst_pin_n <= 1'b1;
    wait_idle();
    tick(20);
    strobe(3, 8'h00);
    run_seq(4, 8'h0F);
    strobe(0, CMD_CHIP_RESET);
    chk(8'(chip_rst), 8'h01);
    tick(5);
    chk({chip_rst, irq, src}, {2'b01, IRQ_RESET});
    chk({busy, controller_function_enable, mode}, {2'b00, MODE_RST_VAL});
    summarize();
  end
endmodule // tb_top
